// ### core/emt_pkg.sv
// Package with register map, field positions, reset values and encodings for the modulo timer
package emt_pkg;

  // Data width of every timer register
  localparam int unsigned EMT_DW = 8;

  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] EMT_IDX_SC = 6'h18;
  localparam logic [5:0] EMT_IDX_CLK = 6'h19;
  localparam logic [5:0] EMT_IDX_CNT = 6'h1A;
  localparam logic [5:0] EMT_IDX_MOD = 6'h1B;

  // Values after reset
  localparam logic [7:0] EMT_SC_RST = 8'h10;
  localparam logic [7:0] EMT_CLK_RST = 8'h00;
  localparam logic [7:0] EMT_CNT_RST = 8'h00;
  localparam logic [7:0] EMT_MOD_RST = 8'h00;

  // Status and control field positions
  localparam int unsigned EMT_SC_OVF_BIT = 7;
  localparam int unsigned EMT_SC_IE_BIT = 6;
  localparam int unsigned EMT_SC_TRST_BIT = 5;
  localparam int unsigned EMT_SC_HALT_BIT = 4;

  // Clock configuration field positions
  localparam int unsigned EMT_CLK_SRC_MSB = 5;
  localparam int unsigned EMT_CLK_SRC_LSB = 4;
  localparam int unsigned EMT_CLK_PS_MSB = 3;
  localparam int unsigned EMT_CLK_PS_LSB = 0;

  // Count at which an unmodified free run wraps
  localparam logic [7:0] EMT_FREE_RUN_TOP = 8'hFF;

  // Prescaler source encodings
  typedef enum logic [1:0] {
    EMT_SRC_BUS = 2'h0,
    EMT_SRC_FIXED = 2'h1,
    EMT_SRC_EXT_RISE = 2'h2,
    EMT_SRC_EXT_FALL = 2'h3
  } emt_src_t;

endpackage

// ### core/emt_prescaler.sv
// Prescaler: source edge selection and power-of-two divider producing count ticks
`timescale 1ns/1ps
module emt_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire emt_pkg::emt_src_t src_sel,
  input wire logic [3:0] ps_sel,
  // Synchronised source edges
  input wire logic fixed_rise,
  input wire logic ext_rise,
  input wire logic ext_fall,
  // Control
  input wire logic run,
  input wire logic clear,
  // Tick out
  output logic tick_q
);

  logic [7:0] pre_q;
  logic [7:0] mask;
  logic src_edge;
  logic at_top;

  // Divider mask: bit i takes part when the ratio exceeds 2**i; codes above 8 act as 256
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign mask[i] = (ps_sel > 4'(i));
  end

  // Pick the edge that feeds the divider
  always_comb begin
    unique case (src_sel)
      emt_pkg::EMT_SRC_BUS: src_edge = 1'b1;
      emt_pkg::EMT_SRC_FIXED: src_edge = fixed_rise;
      emt_pkg::EMT_SRC_EXT_RISE: src_edge = ext_rise;
      emt_pkg::EMT_SRC_EXT_FALL: src_edge = ext_fall;
    endcase
  end

  assign at_top = ((pre_q & mask) == mask);

  // Divider counter; frozen while not running so a resumed count keeps its phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= emt_pkg::EMT_CNT_RST;
    end else if (clear) begin
      pre_q <= emt_pkg::EMT_CNT_RST;
    end else if (run && src_edge) begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // One tick per 2**ps_sel selected edges; codes above 8 give one per 256
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= run && !clear && src_edge && at_top;
    end
  end

  a_div_by_one: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !clear && src_edge && ps_sel == 4'h0) |=> tick_q)
    else $error("prescaler with ratio one missed a tick");

endmodule

// ### core/emt_timer.sv
// Eight-bit modulo timer with APB register access, clock source selection and overflow flag
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module emt_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources from outside this domain
  input wire logic fixed_frequency_clock,
  input wire logic external_timer_clock_pin,
  // Chip operating modes, same clock domain
  input wire logic low_power_halt_state,
  input wire logic debug_active,
  // Overflow interrupt request
  output logic overflow_irq
);

  // Register state
  logic overflow_flag_q;
  logic overflow_irq_enable_q;
  logic counter_halt_control_q;
  logic [1:0] clock_source_select_q;
  logic [3:0] prescale_select_q;
  logic [7:0] count_q;
  logic [7:0] wrap_limit_q;
  logic clear_armed_q;
  logic irq_q;

  // Bus state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Synchronisers and edge history
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic fix_meta_q;
  logic fix_sync_q;
  logic fix_prev_q;

  // Decoded bus terms
  logic acc_wait;
  logic acc_done;
  logic hit_sc;
  logic hit_clk;
  logic hit_cnt;
  logic hit_mod;
  logic hit_any;
  logic sc_wr;
  logic clk_wr;
  logic mod_wr;
  logic sc_rd;
  logic cnt_rst_wr;
  logic flag_sw_clear;

  // Counting terms
  logic count_en;
  logic tick;
  logic advance;
  logic wrap;
  logic [7:0] wrap_top;
  logic [7:0] rd_value;

  // Two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= external_timer_clock_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // Fixed clock is slow against the bus clock, so it is sampled like a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fix_meta_q <= 1'b0;
      fix_sync_q <= 1'b0;
      fix_prev_q <= 1'b0;
    end else begin
      fix_meta_q <= fixed_frequency_clock;
      fix_sync_q <= fix_meta_q;
      fix_prev_q <= fix_sync_q;
    end
  end

  // Address decode: word aligned, index in the upper six bits
  assign hit_sc = (paddr[7:2] == emt_pkg::EMT_IDX_SC) && (paddr[1:0] == 2'h0);
  assign hit_clk = (paddr[7:2] == emt_pkg::EMT_IDX_CLK) && (paddr[1:0] == 2'h0);
  assign hit_cnt = (paddr[7:2] == emt_pkg::EMT_IDX_CNT) && (paddr[1:0] == 2'h0);
  assign hit_mod = (paddr[7:2] == emt_pkg::EMT_IDX_MOD) && (paddr[1:0] == 2'h0);
  assign hit_any = hit_sc || hit_clk || hit_cnt || hit_mod;

  // Access phase takes two cycles: one wait, then pready
  assign acc_wait = psel && penable && !pready_q;
  assign acc_done = psel && penable && pready_q;
  assign sc_wr = acc_done && pwrite && hit_sc;
  assign clk_wr = acc_done && pwrite && hit_clk;
  assign mod_wr = acc_done && pwrite && hit_mod;
  assign sc_rd = acc_done && !pwrite && hit_sc;
  assign cnt_rst_wr = sc_wr && pwdata[emt_pkg::EMT_SC_TRST_BIT];
  assign flag_sw_clear = sc_wr && clear_armed_q && !pwdata[emt_pkg::EMT_SC_OVF_BIT];

  // Read mux; counter reset bit and reserved bits always read zero
  always_comb begin
    rd_value = 8'h00;
    if (hit_sc) begin
      rd_value[emt_pkg::EMT_SC_OVF_BIT] = overflow_flag_q;
      rd_value[emt_pkg::EMT_SC_IE_BIT] = overflow_irq_enable_q;
      rd_value[emt_pkg::EMT_SC_HALT_BIT] = counter_halt_control_q;
    end else if (hit_clk) begin
      rd_value[emt_pkg::EMT_CLK_SRC_MSB:emt_pkg::EMT_CLK_SRC_LSB] = clock_source_select_q;
      rd_value[emt_pkg::EMT_CLK_PS_MSB:emt_pkg::EMT_CLK_PS_LSB] = prescale_select_q;
    end else if (hit_cnt) begin
      rd_value = count_q;
    end else if (hit_mod) begin
      rd_value = wrap_limit_q;
    end
  end

  // Bus answer; read data is captured in the wait cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (acc_wait) begin
      pready_q <= 1'b1;
      pslverr_q <= !hit_any;
      prdata_q <= {24'h00_0000, rd_value};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Status and control bits; reset leaves the counter halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_q <= emt_pkg::EMT_SC_RST[emt_pkg::EMT_SC_IE_BIT];
      counter_halt_control_q <= emt_pkg::EMT_SC_RST[emt_pkg::EMT_SC_HALT_BIT];
    end else if (sc_wr) begin
      overflow_irq_enable_q <= pwdata[emt_pkg::EMT_SC_IE_BIT];
      counter_halt_control_q <= pwdata[emt_pkg::EMT_SC_HALT_BIT];
    end
  end

  // Clock configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_q <= emt_pkg::EMT_CLK_RST[emt_pkg::EMT_CLK_SRC_MSB:
                                                    emt_pkg::EMT_CLK_SRC_LSB];
      prescale_select_q <= emt_pkg::EMT_CLK_RST[emt_pkg::EMT_CLK_PS_MSB:
                                                emt_pkg::EMT_CLK_PS_LSB];
    end else if (clk_wr) begin
      clock_source_select_q <= pwdata[emt_pkg::EMT_CLK_SRC_MSB:emt_pkg::EMT_CLK_SRC_LSB];
      prescale_select_q <= pwdata[emt_pkg::EMT_CLK_PS_MSB:emt_pkg::EMT_CLK_PS_LSB];
    end
  end

  // Modulo register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_limit_q <= emt_pkg::EMT_MOD_RST;
    end else if (mod_wr) begin
      wrap_limit_q <= pwdata[7:0];
    end
  end

  // Counting gate: halt, stop mode and debug all freeze the count; wait mode does not
  assign count_en = !counter_halt_control_q
                    && !low_power_halt_state && !debug_active;

  emt_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_sel(emt_pkg::emt_src_t'(clock_source_select_q)),
    .ps_sel(prescale_select_q),
    .fixed_rise(fix_sync_q && !fix_prev_q),
    .ext_rise(ext_sync_q && !ext_prev_q),
    .ext_fall(!ext_sync_q && ext_prev_q),
    .run(count_en),
    .clear(cnt_rst_wr || mod_wr),
    .tick_q(tick)
  );

  // Modulo zero means the full eight-bit range
  assign wrap_top = (wrap_limit_q == 8'h00) ? emt_pkg::EMT_FREE_RUN_TOP : wrap_limit_q;
  assign wrap = (count_q == wrap_top);
  // Tick is regated since it is one cycle old; a held count must not move
  assign advance = tick && count_en && !cnt_rst_wr && !mod_wr;

  // Counter; writes of counter reset or modulo restart from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= emt_pkg::EMT_CNT_RST;
    end else if (cnt_rst_wr || mod_wr) begin
      count_q <= emt_pkg::EMT_CNT_RST;
    end else if (advance) begin
      count_q <= wrap ? 8'h00 : count_q + 8'h01;
    end
  end

  // Overflow flag; a wrap in the same cycle as a software clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= emt_pkg::EMT_SC_RST[emt_pkg::EMT_SC_OVF_BIT];
    end else if (advance && wrap) begin
      overflow_flag_q <= 1'b1;
    end else if (cnt_rst_wr || mod_wr || flag_sw_clear) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // Clear arming: only a status read that returned the flag set allows the next write of zero;
  // the flag may rise between capture and completion, and software must not clear it unseen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_armed_q <= 1'b0;
    end else if (sc_wr) begin
      clear_armed_q <= 1'b0;
    end else if (sc_rd && prdata_q[emt_pkg::EMT_SC_OVF_BIT]) begin
      clear_armed_q <= 1'b1;
    end else if (!overflow_flag_q) begin
      clear_armed_q <= 1'b0;
    end
  end

  // Level request; in stop mode the flag cannot set, so no wake from stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= overflow_flag_q && overflow_irq_enable_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign overflow_irq = irq_q;

  a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && wrap) |=> (overflow_flag_q && count_q == 8'h00))
    else $error("wrap did not set the flag and zero the counter");

  a_free_run_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && wrap_limit_q == 8'h00 && count_q == 8'hFF) |=> (count_q == 8'h00))
    else $error("free run did not wrap from FF");

  a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (counter_halt_control_q && !cnt_rst_wr && !mod_wr) |=> $stable(count_q))
    else $error("counter moved while halted");

  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (low_power_halt_state && !cnt_rst_wr && !mod_wr)
      |=> ($stable(count_q) && !$rose(overflow_flag_q)))
    else $error("counter moved in stop mode");

  a_debug_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (debug_active && !cnt_rst_wr && !mod_wr) |=> $stable(count_q))
    else $error("counter moved during debug");

  a_cnt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_rst_wr |=> (count_q == 8'h00 && !overflow_flag_q))
    else $error("counter reset write did not clear counter and flag");

  a_mod_write: assert property (@(posedge pclk) disable iff (!presetn)
    mod_wr |=> (wrap_limit_q == $past(pwdata[7:0]) && count_q == 8'h00 && !overflow_flag_q))
    else $error("modulo write did not load and restart");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (overflow_flag_q && overflow_irq_enable_q) ##1 (overflow_flag_q && overflow_irq_enable_q)
      |-> overflow_irq)
    else $error("request missing while flag and enable set");

  a_trst_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready_q && $past(acc_wait && !pwrite && hit_sc))
      |-> (prdata[emt_pkg::EMT_SC_TRST_BIT] == 1'b0))
    else $error("counter reset bit read back as one");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (advance && !wrap) |=> (count_q == $past(count_q) + 8'h01))
    else $error("counter did not step by one on a tick");

endmodule

// ### tb/emt_ext_src.sv
// Behavioural external clock source that drives the timer clock pin
`timescale 1ns/1ps
module emt_ext_src #(
  parameter int HALF = 2
) (
  // Clock and enable
  input wire logic pclk,
  input wire logic run,
  // Pin drive
  output logic pin
);
  int cnt = 0;
  initial pin = 1'b0;
  // Half period of HALF bus cycles keeps the pin at or below a quarter of pclk
  // The pin stands low while disabled, so no stray edge reaches the timer
  always @(posedge pclk) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### tb/tb.sv
// Self-checking testbench for the modulo timer
`timescale 1ns/1ps
module tb;
  localparam int LIMIT = 40000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic fixed_clk = 1'b0;
  logic fixed_on = 1'b0;
  logic ext_run = 1'b0;
  logic stop_m = 1'b0;
  logic dbg = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic ext_pin;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] a_sc;
  logic [7:0] a_clk;
  logic [7:0] a_cnt;
  logic [7:0] a_mod;
  assign a_sc = {emt_pkg::EMT_IDX_SC, 2'b00};
  assign a_clk = {emt_pkg::EMT_IDX_CLK, 2'b00};
  assign a_cnt = {emt_pkg::EMT_IDX_CNT, 2'b00};
  assign a_mod = {emt_pkg::EMT_IDX_MOD, 2'b00};

  always #4 pclk = ~pclk;

  emt_timer dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixed_frequency_clock(fixed_clk), .external_timer_clock_pin(ext_pin),
    .low_power_halt_state(stop_m), .debug_active(dbg), .overflow_irq(irq)
  );
  emt_ext_src #(.HALF(2)) src_u (.pclk(pclk), .run(ext_run), .pin(ext_pin));

  // Cycle count drives the fixed clock (period 8) and cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    fixed_clk <= fixed_on & cyc[2];
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Count windows carry pipeline and prescaler phase slack of tol
  task automatic chk_near(input logic [31:0] got, input int exp, input int tol);
    int d;
    d = int'(got) - exp;
    cmp_count++;
    if ((^got === 1'bx) || d > tol || d < -tol) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  // No local bound on the wait: a slave that never answers is caught by the cycle limit
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({8'h00, rd[31:8]}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 8'h00, v, e);
  endtask

  task automatic check_reset();
    logic [31:0] v;
    rd(a_sc, v); chk(v, {24'h0, emt_pkg::EMT_SC_RST});
    rd(a_clk, v); chk(v, {24'h0, emt_pkg::EMT_CLK_RST});
    rd(a_cnt, v); chk(v, {24'h0, emt_pkg::EMT_CNT_RST});
    rd(a_mod, v); chk(v, {24'h0, emt_pkg::EMT_MOD_RST});
    chk({31'h0, irq}, 32'h0);
  endtask

  // Reset values, reserved bits, read-only counter and unmapped places
  task automatic t_regs();
    logic [31:0] v;
    logic e;
    check_reset();
    apb(1'b0, 8'h70, 8'h00, v, e); chk({v[30:0], e}, 32'h1);
    apb(1'b1, 8'h61, 8'hFF, v, e); chk({31'h0, e}, 32'h1);
    wr(a_cnt, 8'h55); rd(a_cnt, v); chk(v, 32'h0);
    wr(a_clk, 8'hFF); rd(a_clk, v); chk(v, 32'h3F);
    wr(a_sc, 8'h5F); rd(a_sc, v); chk(v, 32'h50);
    wr(a_mod, 8'hA5); rd(a_mod, v); chk(v, 32'hA5);
    wr(a_sc, 8'h10);
    wr(a_mod, 8'h00);
    $display("test regs finished");
  endtask

  // Count over a window between the start and the halt write
  task automatic meas(input logic [7:0] cfg, input int win, input int exp, input int tol);
    logic [31:0] v;
    wr(a_clk, cfg);
    wr(a_sc, 8'h30);
    wr(a_sc, 8'h00);
    repeat (win) @(posedge pclk);
    wr(a_sc, 8'h10);
    rd(a_cnt, v);
    chk_near(v, exp, tol);
  endtask

  task automatic t_prescale();
    int dv;
    for (int k = 0; k < 10; k++) begin
      dv = (k > 8) ? 256 : (1 << k);
      meas(8'(k), 24 * dv, (24 * dv + 3) / dv, 2);
    end
    $display("test prescale finished");
  endtask

  task automatic t_sources();
    fixed_on <= 1'b1;
    ext_run <= 1'b1;
    meas(8'h10, 160, 20, 2);
    meas(8'h20, 160, 40, 2);
    meas(8'h30, 160, 40, 2);
    ext_run <= 1'b0;
    meas(8'h20, 100, 0, 0);
    fixed_on <= 1'b0;
    $display("test sources finished");
  endtask

  task automatic poll_flag();
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      rd(a_sc, v);
      n++;
    end while (v[7] !== 1'b1 && n < 120);
    chk({31'h0, v[7]}, 32'h1);
  endtask

  // Wrap, flag set and clear paths, interrupt level
  task automatic t_overflow();
    logic [31:0] v;
    wr(a_clk, 8'h00);
    wr(a_mod, 8'h03); wr(a_sc, 8'h00); poll_flag();
    wr(a_sc, 8'h90); rd(a_cnt, v); chk({31'h0, v <= 32'h3}, 32'h1);
    wr(a_mod, 8'h00); wr(a_sc, 8'h00); poll_flag();
    wr(a_sc, 8'hD0); repeat (2) @(posedge pclk); chk({31'h0, irq}, 32'h1);
    wr(a_sc, 8'h90); repeat (2) @(posedge pclk); chk({31'h0, irq}, 32'h0);
    wr(a_sc, 8'h10); rd(a_sc, v); chk(v, 32'h90);
    wr(a_sc, 8'h10); rd(a_sc, v); chk(v, 32'h10);
    wr(a_mod, 8'h03); wr(a_sc, 8'h00); poll_flag();
    wr(a_sc, 8'hB0); rd(a_sc, v); chk(v, 32'h10);
    rd(a_cnt, v); chk(v, 32'h0);
    wr(a_sc, 8'h00); poll_flag();
    wr(a_sc, 8'h90); wr(a_mod, 8'h03); rd(a_sc, v); chk(v, 32'h10);
    rd(a_cnt, v); chk(v, 32'h0);
    $display("test overflow finished");
  endtask

  // Stop and debug freeze the count; halt control holds it
  task automatic t_modes();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    wr(a_clk, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(a_mod, 8'h00);
      wr(a_sc, 8'h20);
      repeat (20) @(posedge pclk);
      if (i == 0) stop_m <= 1'b1;
      else dbg <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(a_cnt, a);
      repeat (40) @(posedge pclk);
      rd(a_cnt, b); chk(b, a);
      if (i == 1) begin
        wr(a_sc, 8'h20); rd(a_cnt, b); chk(b, 32'h0);
      end
      stop_m <= 1'b0;
      dbg <= 1'b0;
      repeat (20) @(posedge pclk);
      rd(a_cnt, c); chk({31'h0, c > b}, 32'h1);
    end
    wr(a_sc, 8'h10);
    rd(a_cnt, a);
    repeat (30) @(posedge pclk);
    rd(a_cnt, b); chk(b, a);
    $display("test modes finished");
  endtask

  // Reset in mid-run restores every register
  task automatic t_reset();
    wr(a_mod, 8'h07);
    wr(a_clk, 8'h05);
    wr(a_sc, 8'h60);
    repeat (30) @(posedge pclk);
    // Reset arrives while the chip sits in stop mode, so leaving stop by reset is covered
    stop_m <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    stop_m <= 1'b0;
    check_reset();
    $display("test reset finished");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prescale();
    t_sources();
    t_overflow();
    t_modes();
    t_reset();
    stop_test();
  end
endmodule
